// ==== spf_flash_ctrl.sv ====
// Purpose: self-programming sequencer for on-chip program flash
// Assumes: core store/load strobes and flash done are on CLK; AHB-Lite slave
// Notes:   zero-wait-state slave, always OKAY; lock byte held in flops
`timescale 1ns/10ps

// Function
// [RULE1] ready interrupt requested while enabled, global enable set, enable bit clear
// [RULE2] erase/write to concurrent section sets busy flag, blocking that section
// [RULE3] busy flag cleared by re-enable after completion or by buffer fill
// [RULE4] signature mode: load in three cycles reads signature, store does nothing
// [RULE5] re-enable store in four cycles, refused while erase or write runs
// [RULE6] re-enable written during buffer fill discards the buffer contents
// [RULE7] lock-write store takes lock bits from R0; bit clears at end or timeout
// [RULE8] load in three cycles of lock-write returns lock or fuse by pointer bit 0
// [RULE9] page write programs pointer page from buffer; clears at end or timeout
// [RULE10] page erase erases pointer page; clears at end or timeout
// [RULE11] erase or write to stalling section halts core for whole operation
// [RULE12] plain enable: store puts R1:R0 in buffer word, pointer bit 0 ignored
// [RULE13] enable arms four cycles, clears on store or timeout, holds during flash
// [RULE14] only five listed low-bit patterns take effect
// [RULE15] lock bits only go one to zero; chip erase returns them to one
// [RULE16] no-boot variant: store allowed only when self-program fuse is zero
// [RULE17] memory-lock mode 2 blocks external programming and locks fuses
// [RULE18] memory-lock mode 3 also blocks verify and locks boot-lock bits
// [RULE19] app-lock modes 2,3 block stores to application section
// [RULE20] app-lock modes 3,4 block boot loads of app; vectors in boot mask irq
// [RULE21] boot-lock modes 2,3 block stores to boot section
// [RULE22] boot-lock modes 3,4 block app loads of boot; vectors in app mask irq
module spf_flash_ctrl #(
  parameter bit HAS_BOOT_SECTION = 1'b1
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        STORE_REQ,
  input  wire logic        LOAD_REQ,
  input  wire logic [15:0] PTR_Z,
  input  wire logic [7:0]  REG_R0,
  input  wire logic [7:0]  REG_R1,
  input  wire logic        GLOBAL_IRQ_EN,
  input  wire logic        EXEC_IN_BOOT,
  input  wire logic        VECTORS_IN_BOOT,
  input  wire logic        SELF_PROG_FUSE_N,
  input  wire logic        CHIP_ERASE,
  input  wire logic [7:0]  FUSE_DATA,
  input  wire logic [7:0]  SIG_DATA,
  input  wire logic [7:0]  FLASH_RD_DATA,
  input  wire logic        FLASH_DONE,
  input  wire logic [5:0]  FLASH_WORD_SEL,
  output logic      [15:0] FLASH_WR_DATA,
  output logic             FLASH_ERASE,
  output logic             FLASH_WRITE,
  output logic      [7:0]  FLASH_PAGE,
  output logic      [7:0]  LOAD_DATA,
  output logic             LOAD_VALID,
  output logic             LOAD_DENIED,
  output logic             CPU_STALL,
  output logic             SECTION_BLOCKED,
  output logic             STORE_READY_IRQ,
  output logic             IRQ_MASK,
  output logic             EXT_PROG_ALLOW,
  output logic             EXT_VERIFY_ALLOW,
  output logic             EXT_FUSE_WR_ALLOW,
  output logic             EXT_BOOT_LOCK_WR_ALLOW
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  spf_pkg::spf_ctrl_t  ctrl_q,    ctrl_d;
  spf_pkg::spf_state_t state_q,   state_d;
  logic [2:0]          cnt_q,     cnt_d;
  logic [7:0]          lock_q,    lock_d;
  logic                stall_q,   stall_d;
  logic                erase_q,   erase_d;
  logic                write_q,   write_d;
  logic [7:0]          page_q,    page_d;
  logic [7:0]          ldata_q,   ldata_d;
  logic                lvalid_q,  lvalid_d;
  logic                ldeny_q,   ldeny_d;
  logic                irq_q,     irq_d;
  logic                imask_q,   imask_d;
  logic [3:0]          ext_q,     ext_d;
  logic                filling_q, filling_d;
  logic                aw_q,      aw_d;
  logic                ar_q,      ar_d;
  logic [9:0]          aaddr_q,   aaddr_d;
  logic [31:0]         rdata_q,   rdata_d;

  logic [15:0]         buf_mem [spf_pkg::BUF_WORDS];
  logic                buf_we;
  logic                buf_clr;

  // ---------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------
  logic [7:0] z_page;
  logic [5:0] z_word;
  logic       tgt_boot;
  logic       tgt_conc;
  logic [1:0] app_mode;
  logic [1:0] boot_mode;
  logic [1:0] mem_mode;
  logic       app_st_blk;
  logic       boot_st_blk;
  logic       app_ld_blk;
  logic       boot_ld_blk;
  logic       store_ok;
  logic       ctrl_wr;
  logic [7:0] wbyte;
  logic [4:0] wpat;
  logic       pat_ok;
  logic       addr_ph;

  always_comb
  begin
    z_page      = PTR_Z[spf_pkg::PAGE_MSB:spf_pkg::PAGE_LSB];
    z_word      = PTR_Z[spf_pkg::WORD_MSB:spf_pkg::WORD_LSB];
    tgt_boot    = z_page >= spf_pkg::BOOT_PAGE;
    tgt_conc    = z_page < spf_pkg::STALLING_SECTION_PAGE;
    app_mode    = {lock_q[spf_pkg::ALOCK_HI], lock_q[spf_pkg::ALOCK_LO]};
    boot_mode   = {lock_q[spf_pkg::BLOCK_HI], lock_q[spf_pkg::BLOCK_LO]};
    mem_mode    = {lock_q[spf_pkg::MLOCK_HI], lock_q[spf_pkg::MLOCK_LO]};
    // hi bit zero means mode 3 or 4 (load blocked); lo zero means store blocked
    app_st_blk  = ~app_mode[0];                                     // RULE19
    boot_st_blk = ~boot_mode[0];                                    // RULE21
    app_ld_blk  = ~app_mode[1];                                     // RULE20
    boot_ld_blk = ~boot_mode[1];                                    // RULE22
    store_ok    = HAS_BOOT_SECTION | ~SELF_PROG_FUSE_N;             // RULE16
    addr_ph     = HSEL & HREADY & (HTRANS == spf_pkg::HTRANS_NONSEQ
                                 | HTRANS == spf_pkg::HTRANS_SEQ);
    ctrl_wr     = aw_q & (aaddr_q == spf_pkg::CTRL_ADDR);
    wbyte       = HWDATA[7:0];
    wpat        = wbyte[4:0];
    pat_ok      = (wpat == spf_pkg::PAT_FILL)  | (wpat == spf_pkg::PAT_ERASE)
                | (wpat == spf_pkg::PAT_WRITE) | (wpat == spf_pkg::PAT_LOCK)
                | (wpat == spf_pkg::PAT_REEN);                      // RULE14
  end

  // ---------------------------------------------------------------------
  // bus slave: address captured, write/read done in data phase
  // ---------------------------------------------------------------------
  always_comb
  begin
    aw_d    = addr_ph & HWRITE;
    ar_d    = addr_ph & ~HWRITE;
    aaddr_d = addr_ph ? HADDR[9:0] : aaddr_q;
    rdata_d = 32'h0000_0000;
    if (addr_ph & ~HWRITE)
    begin
      if (HADDR[9:0] == spf_pkg::CTRL_ADDR)
        rdata_d = {24'h00_0000, ctrl_q};
      else if (HADDR[9:0] == spf_pkg::LOCK_ADDR)
        rdata_d = {24'h00_0000, lock_q};
    end
  end

  // ---------------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------------
  always_comb
  begin
    ctrl_d    = ctrl_q;
    state_d   = state_q;
    cnt_d     = cnt_q;
    lock_d    = lock_q;
    stall_d   = stall_q;
    erase_d   = 1'b0;
    write_d   = 1'b0;
    page_d    = page_q;
    ldata_d   = ldata_q;
    lvalid_d  = 1'b0;
    ldeny_d   = 1'b0;
    filling_d = filling_q;
    buf_we    = 1'b0;
    buf_clr   = 1'b0;

    case (state_q)
      spf_pkg::ST_IDLE:
      begin
        if (ctrl_wr & pat_ok)
        begin
          // signature bit rides only on the plain enable pattern
          ctrl_d.signature_row_read          = wbyte[5] &
                                               (wpat == spf_pkg::PAT_FILL);
          ctrl_d.concurrent_section_reenable = wbyte[4];
          ctrl_d.lock_bits_write             = wbyte[3];
          ctrl_d.page_write_cmd              = wbyte[2];
          ctrl_d.page_erase_cmd              = wbyte[1];
          ctrl_d.store_command_enable        = 1'b1;
          cnt_d   = spf_pkg::ARM_CYCLES;                            // RULE13
          state_d = spf_pkg::ST_ARMED;
          if (wbyte[4] & filling_q)
          begin
            buf_clr   = 1'b1;                                       // RULE6
            filling_d = 1'b0;
          end
        end
      end
      spf_pkg::ST_ARMED:
      begin
        cnt_d = cnt_q - 3'h1;
        if (LOAD_REQ & (cnt_q >= spf_pkg::LOAD_MIN)
            & (ctrl_q.signature_row_read | ctrl_q.lock_bits_write))
        begin
          lvalid_d = 1'b1;
          if (ctrl_q.signature_row_read)
            ldata_d = SIG_DATA;                                     // RULE4
          else
            ldata_d = PTR_Z[0] ? lock_q : FUSE_DATA;                // RULE8
          ctrl_d.signature_row_read   = 1'b0;
          ctrl_d.lock_bits_write      = 1'b0;
          ctrl_d.store_command_enable = 1'b0;
          state_d = spf_pkg::ST_IDLE;
        end
        else if (STORE_REQ)
        begin
          ctrl_d.signature_row_read          = 1'b0;
          ctrl_d.concurrent_section_reenable = 1'b0;
          ctrl_d.lock_bits_write             = 1'b0;
          ctrl_d.store_command_enable        = 1'b0;
          state_d = spf_pkg::ST_IDLE;
          if (ctrl_q.signature_row_read | ~store_ok)
          begin
            // store is a no-op in signature mode or when disabled
          end                                                       // RULE4
          else if (ctrl_q.concurrent_section_reenable)
            ctrl_d.concurrent_section_busy = 1'b0;                  // RULE5
          else if (ctrl_q.lock_bits_write)
            lock_d = lock_q & (REG_R0 | spf_pkg::LOCK_KEEP);        // RULE7
          else if (ctrl_q.page_erase_cmd | ctrl_q.page_write_cmd)
          begin
            if ((tgt_boot & boot_st_blk) | (~tgt_boot & app_st_blk))
            begin
              ctrl_d.page_erase_cmd = 1'b0;                         // RULE19
              ctrl_d.page_write_cmd = 1'b0;                         // RULE21
            end
            else
            begin
              // enable holds until the flash reports completion
              ctrl_d.store_command_enable = 1'b1;                   // RULE13
              page_d  = z_page;
              erase_d = ctrl_q.page_erase_cmd;                      // RULE10
              write_d = ctrl_q.page_write_cmd;                      // RULE9
              if (tgt_conc)
                ctrl_d.concurrent_section_busy = 1'b1;              // RULE2
              else
                stall_d = 1'b1;                                     // RULE11
              state_d = spf_pkg::ST_FLASH;
              if (ctrl_q.page_write_cmd)
                filling_d = 1'b0;
            end
          end
          else
          begin
            buf_we    = 1'b1;                                       // RULE12
            filling_d = 1'b1;
            ctrl_d.concurrent_section_busy = 1'b0;                  // RULE3
          end
        end
        else if (cnt_q == 3'h1)
        begin
          // window expired with no store: drop every command bit
          ctrl_d.signature_row_read          = 1'b0;
          ctrl_d.concurrent_section_reenable = 1'b0;
          ctrl_d.lock_bits_write             = 1'b0;
          ctrl_d.page_write_cmd              = 1'b0;
          ctrl_d.page_erase_cmd              = 1'b0;
          ctrl_d.store_command_enable        = 1'b0;            // RULE13
          state_d = spf_pkg::ST_IDLE;
        end
      end
      spf_pkg::ST_FLASH:
      begin
        // command bits of control writes are ignored here (only the irq enable bit is taken), so re-enable cannot slip in
        if (FLASH_DONE)
        begin
          ctrl_d.page_write_cmd       = 1'b0;                       // RULE9
          ctrl_d.page_erase_cmd       = 1'b0;                       // RULE10
          ctrl_d.store_command_enable = 1'b0;                       // RULE13
          stall_d = 1'b0;                                           // RULE11
          state_d = spf_pkg::ST_IDLE;
        end
      end
      default:
        state_d = spf_pkg::ST_IDLE;
    endcase

    // interrupt enable is a plain bit, written whatever the pattern
    if (ctrl_wr)
      ctrl_d.store_ready_irq_enable = wbyte[7];

    // ordinary loads: section protection and busy blocking
    if (LOAD_REQ & ~lvalid_d)
    begin
      lvalid_d = 1'b1;
      if ((tgt_conc & ctrl_q.concurrent_section_busy)             // RULE2
          | (EXEC_IN_BOOT & ~tgt_boot & app_ld_blk)               // RULE20
          | (~EXEC_IN_BOOT & tgt_boot & boot_ld_blk))             // RULE22
      begin
        ldeny_d = 1'b1;
        ldata_d = spf_pkg::LOCK_RESET;
      end
      else
        ldata_d = FLASH_RD_DATA;
    end

    if (CHIP_ERASE)
      lock_d = spf_pkg::LOCK_RESET;                                 // RULE15

    irq_d   = ctrl_d.store_ready_irq_enable & GLOBAL_IRQ_EN
              & ~ctrl_d.store_command_enable;                       // RULE1
    imask_d = (app_ld_blk & VECTORS_IN_BOOT & ~EXEC_IN_BOOT)        // RULE20
            | (boot_ld_blk & ~VECTORS_IN_BOOT & EXEC_IN_BOOT);      // RULE22
    // order: prog, verify, fuse write, boot-lock write
    ext_d   = {~(mem_mode != 2'b11),                                // RULE17
               ~(mem_mode == 2'b00),                                // RULE18
               ~(mem_mode != 2'b11),                                // RULE17
               ~(mem_mode == 2'b00)};                               // RULE18
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl_q    <= spf_pkg::CTRL_RESET;
      state_q   <= spf_pkg::ST_IDLE;
      cnt_q     <= 3'h0;
      lock_q    <= spf_pkg::LOCK_RESET;
      stall_q   <= 1'b0;
      erase_q   <= 1'b0;
      write_q   <= 1'b0;
      page_q    <= 8'h00;
      ldata_q   <= 8'h00;
      lvalid_q  <= 1'b0;
      ldeny_q   <= 1'b0;
      irq_q     <= 1'b0;
      imask_q   <= 1'b0;
      ext_q     <= 4'hF;
      filling_q <= 1'b0;
      aw_q      <= 1'b0;
      ar_q      <= 1'b0;
      aaddr_q   <= 10'h000;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      lock_q    <= lock_d;
      stall_q   <= stall_d;
      erase_q   <= erase_d;
      write_q   <= write_d;
      page_q    <= page_d;
      ldata_q   <= ldata_d;
      lvalid_q  <= lvalid_d;
      ldeny_q   <= ldeny_d;
      irq_q     <= irq_d;
      imask_q   <= imask_d;
      ext_q     <= ext_d;
      filling_q <= filling_d;
      aw_q      <= aw_d;
      ar_q      <= ar_d;
      aaddr_q   <= aaddr_d;
      rdata_q   <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------
  // temporary page buffer
  // ---------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < spf_pkg::BUF_WORDS; gi++)
    begin : g_buf
      logic [15:0] word_d;
      always_comb
      begin
        word_d = buf_mem[gi];
        if (buf_clr | RST)
          word_d = spf_pkg::BUF_ERASED;                             // RULE6
        else if (buf_we & (z_word == 6'(gi)))
          word_d = {REG_R1, REG_R0};                                // RULE12
      end
      always_ff @(posedge CLK)
      begin
        buf_mem[gi] <= word_d;
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign HRDATA                 = rdata_q;
  assign HREADYOUT              = 1'b1;
  assign HRESP                  = 1'b0;
  assign FLASH_WR_DATA          = buf_mem[FLASH_WORD_SEL];
  assign FLASH_ERASE            = erase_q;
  assign FLASH_WRITE            = write_q;
  assign FLASH_PAGE             = page_q;
  assign LOAD_DATA              = ldata_q;
  assign LOAD_VALID             = lvalid_q;
  assign LOAD_DENIED            = ldeny_q;
  assign CPU_STALL              = stall_q;
  assign SECTION_BLOCKED        = ctrl_q.concurrent_section_busy;
  assign STORE_READY_IRQ        = irq_q;
  assign IRQ_MASK               = imask_q;
  assign EXT_PROG_ALLOW         = ext_q[3];
  assign EXT_VERIFY_ALLOW       = ext_q[2];
  assign EXT_FUSE_WR_ALLOW      = ext_q[1];
  assign EXT_BOOT_LOCK_WR_ALLOW = ext_q[0];

endmodule : spf_flash_ctrl

// ==== spf_flash_ctrl_sva.sv ====
// Purpose: port checks for the flash sequencer
// Assumes: one clock domain, reset on RST
// Notes:   page and stall relations are tied to the store that caused them
`timescale 1ns/10ps
module spf_chk (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        STORE_REQ,
  input wire logic [15:0] PTR_Z,
  input wire logic        GLOBAL_IRQ_EN,
  input wire logic        FLASH_DONE,
  input wire logic        FLASH_ERASE,
  input wire logic        FLASH_WRITE,
  input wire logic [7:0]  FLASH_PAGE,
  input wire logic        CPU_STALL,
  input wire logic        SECTION_BLOCKED,
  input wire logic        STORE_READY_IRQ,
  input wire logic        EXT_PROG_ALLOW,
  input wire logic        EXT_VERIFY_ALLOW,
  input wire logic        EXT_FUSE_WR_ALLOW,
  input wire logic        EXT_BOOT_LOCK_WR_ALLOW
);
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic       op;
  logic [7:0] pg;
  logic       hi;
  assign op = FLASH_ERASE | FLASH_WRITE;
  assign pg = PTR_Z[14:7];
  assign hi = FLASH_PAGE >= spf_pkg::STALLING_SECTION_PAGE;
  property p_op; op |-> $past(STORE_REQ); endproperty
  a_op: assert property (p_op) else $error("op without store");
  property p_pg; op |-> FLASH_PAGE == $past(pg); endproperty
  a_pg: assert property (p_pg) else $error("wrong page");
  property p_bz; op && !hi |-> SECTION_BLOCKED && !CPU_STALL; endproperty
  a_bz: assert property (p_bz) else $error("busy not set");
  property p_st; op && hi |-> CPU_STALL; endproperty
  a_st: assert property (p_st) else $error("no stall");
  property p_sh; CPU_STALL && !FLASH_DONE |=> CPU_STALL; endproperty
  a_sh: assert property (p_sh) else $error("stall dropped");
  property p_iq; STORE_READY_IRQ |-> $past(GLOBAL_IRQ_EN); endproperty
  a_iq: assert property (p_iq) else $error("irq ungated");
  property p_l2; EXT_PROG_ALLOW == EXT_FUSE_WR_ALLOW; endproperty
  a_l2: assert property (p_l2) else $error("fuse lock");
  property p_l3; EXT_VERIFY_ALLOW == EXT_BOOT_LOCK_WR_ALLOW; endproperty
  a_l3: assert property (p_l3) else $error("verify lock");
endmodule : spf_chk
bind spf_flash_ctrl spf_chk u_chk (.*);

// ==== spf_flash_ctrl_tb_top.sv ====
// Purpose: self-checking bench for the flash sequencer
// Assumes: zero-wait bus slave, flash model answers in 20 clocks
// Notes:   an idle cycle before each transfer keeps drivers race free
`timescale 1ns/10ps
module spf_flash_ctrl_tb_top;
  // --------------------------------
  // signals and tables
  // --------------------------------
  localparam logic [9:0] CA = spf_pkg::CTRL_ADDR;
  localparam logic [9:0] LA = spf_pkg::LOCK_ADDR;
  logic CLK = 1'b0, RST = 1'b1, HSEL = 1'b1, HWRITE = 1'b0;
  logic [31:0] HADDR = '0, HWDATA = '0, rd;
  logic [1:0] HTRANS = '0;
  logic [2:0] HSIZE = 3'h2;
  logic STORE_REQ = 1'b0, LOAD_REQ = 1'b0, CHIP_ERASE = 1'b0;
  logic [15:0] PTR_Z = '0;
  logic [7:0] REG_R0 = '0, REG_R1 = '0, FUSE_DATA = 8'h5A;
  logic [7:0] SIG_DATA = 8'h1E, FLASH_RD_DATA = 8'h3C;
  logic GLOBAL_IRQ_EN = 1'b1, EXEC_IN_BOOT = 1'b0;
  logic VECTORS_IN_BOOT = 1'b0, SELF_PROG_FUSE_N = 1'b0;
  logic [5:0] FLASH_WORD_SEL = '0;
  wire logic [31:0] HRDATA;
  wire logic [15:0] FLASH_WR_DATA;
  wire logic [7:0] FLASH_PAGE, LOAD_DATA;
  wire logic HREADYOUT, HRESP, FLASH_DONE, FLASH_ERASE, FLASH_WRITE;
  wire logic LOAD_VALID, LOAD_DENIED, CPU_STALL, SECTION_BLOCKED;
  wire logic STORE_READY_IRQ, IRQ_MASK, EXT_PROG_ALLOW, EXT_VERIFY_ALLOW;
  wire logic EXT_FUSE_WR_ALLOW, EXT_BOOT_LOCK_WR_ALLOW;
  logic [7:0] cm [3] = '{8'h21, 8'h09, 8'h09};
  logic [7:0] le [3] = '{8'h1E, 8'h5A, 8'hFF};
  logic [7:0] rl [4] = '{8'hFB, 8'hF3, 8'hEF, 8'hCF};
  logic [15:0] rz [4] = '{16'h0880, 16'h0880, 16'h7000, 16'h7000};
  int n_checks = 0, n_mismatch = 0, cyc = 0;
  always #12.5 CLK = ~CLK;
  spf_flash_ctrl DUT (.HREADY(HREADYOUT), .*);
  spf_flash_mdl u_mdl (.clk(CLK), .rst(RST),
    .start(FLASH_ERASE | FLASH_WRITE), .done(FLASH_DONE));
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge CLK);
    HADDR <= {22'h0, a};
    HWRITE <= w;
    HTRANS <= spf_pkg::HTRANS_NONSEQ;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask : bus
  task automatic rc(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rc
  task automatic program_store_instr(input logic [15:0] z, input logic [15:0] r);
    PTR_Z <= z;
    {REG_R1, REG_R0} <= r;
    STORE_REQ <= 1'b1;
    @(posedge CLK);
    STORE_REQ <= 1'b0;
    #1;
  endtask : program_store_instr
  task automatic program_load_instr(input logic [15:0] z);
    PTR_Z <= z;
    LOAD_REQ <= 1'b1;
    @(posedge CLK);
    LOAD_REQ <= 1'b0;
    #1;
  endtask : program_load_instr
  task automatic lkw(input logic [7:0] v);
    CHIP_ERASE <= 1'b1;
    @(posedge CLK);
    CHIP_ERASE <= 1'b0;
    bus(1'b1, CA, 8'h09);
    program_store_instr(16'h0000, {8'h00, v});
  endtask : lkw
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      complete_run();
    end
  end
  // --------------------------------
  // tests
  // --------------------------------
  initial
  begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rc(CA, 8'h00);
    rc(LA, 8'hFF);
    rc(10'h3FC, 8'h00);
    bus(1'b1, CA, 8'h07);
    rc(CA, 8'h00);
    bus(1'b1, CA, 8'h01);
    rc(CA, 8'h01);
    repeat (3) @(posedge CLK);
    rc(CA, 8'h00);
    $display("end arming");
    bus(1'b1, CA, 8'h01);
    program_store_instr(16'h0007, 16'hA55A);
    FLASH_WORD_SEL = 6'd3;
    #1 chk(32'(FLASH_WR_DATA), 32'hA55A);
    bus(1'b1, CA, 8'h11);
    #1 chk(32'(FLASH_WR_DATA), 32'hFFFF);
    repeat (4) @(posedge CLK);
    $display("end fill");
    for (int i = 0; i < 2; i++)
    begin
      bus(1'b1, CA, 8'h03);
      program_store_instr(16'h0880, 16'h1234);
      chk(32'({FLASH_ERASE, FLASH_PAGE, SECTION_BLOCKED, CPU_STALL}),
          32'h446);
      program_load_instr(16'h0880);
      chk(32'({LOAD_VALID, LOAD_DENIED}), 32'h3);
      bus(1'b1, CA, 8'h11);
      rc(CA, 8'h43);
      do bus(1'b0, CA, 8'h00); while (rd[0] !== 1'b0);
      chk(rd, 32'h40);
      bus(1'b1, CA, i ? 8'h01 : 8'h11);
      program_store_instr(16'h0000, 16'h0000);
      chk(32'(SECTION_BLOCKED), 32'h0);
    end
    bus(1'b1, CA, 8'h05);
    program_store_instr(16'h7000, 16'h0000);
    chk(32'({FLASH_WRITE, FLASH_PAGE, CPU_STALL}), 32'h3C1);
    while (CPU_STALL !== 1'b0) @(posedge CLK);
    rc(CA, 8'h00);
    $display("end flash");
    bus(1'b1, CA, 8'h80);
    repeat (2) @(posedge CLK);
    chk(32'(STORE_READY_IRQ), 32'h1);
    GLOBAL_IRQ_EN <= 1'b0;
    repeat (2) @(posedge CLK);
    chk(32'(STORE_READY_IRQ), 32'h0);
    GLOBAL_IRQ_EN <= 1'b1;
    bus(1'b1, CA, 8'h81);
    repeat (2) @(posedge CLK);
    chk(32'(STORE_READY_IRQ), 32'h0);
    repeat (4) @(posedge CLK);
    chk(32'(STORE_READY_IRQ), 32'h1);
    bus(1'b1, CA, 8'h00);
    $display("end irq");
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, CA, cm[i]);
      program_load_instr({15'h0, i == 2});
      chk(32'(LOAD_DATA), 32'(le[i]));
    end
    for (int i = 0; i < 4; i++)
    begin
      lkw(rl[i]);
      rc(LA, rl[i]);
      bus(1'b1, CA, 8'h03);
      program_store_instr(rz[i], 16'h0000);
      chk(32'(FLASH_ERASE), 32'h0);
      rc(CA, 8'h00);
    end
    program_load_instr(16'h7000);
    chk(32'({LOAD_DENIED, LOAD_DATA}), 32'h1FF);
    EXEC_IN_BOOT <= 1'b1;
    repeat (2) @(posedge CLK);
    chk(32'(IRQ_MASK), 32'h1);
    lkw(8'hFE);
    rc(LA, 8'hFE);
    chk(32'({EXT_PROG_ALLOW, EXT_VERIFY_ALLOW}), 32'h1);
    lkw(8'hFC);
    rc(LA, 8'hFC);
    chk(32'({EXT_PROG_ALLOW, EXT_VERIFY_ALLOW}), 32'h0);
    bus(1'b1, CA, 8'h09);
    program_store_instr(16'h0000, 16'h00FF);
    rc(LA, 8'hFC);
    $display("end locks");
    complete_run();
  end
endmodule : spf_flash_ctrl_tb_top

// ==== spf_flash_mdl.sv ====
// Purpose: flash array stand-in that ends each operation after DLY clocks
// Assumes: start is a one-cycle pulse from the sequencer
// Notes:   no overlap check, the sequencer runs one operation at a time
`timescale 1ns/10ps
module spf_flash_mdl #(
  parameter int DLY = 20
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      done = 1'b0
);
  // --------------------------------
  // busy countdown
  // --------------------------------
  int cnt_q = 0;
  always @(posedge clk)
  begin
    done <= (cnt_q == 1) && !rst;
    cnt_q <= rst ? 0 : start ? DLY : (cnt_q > 0) ? cnt_q - 1 : 0;
  end
endmodule : spf_flash_mdl

// ==== spf_pkg.sv ====
// Purpose: shared constants and types for the self-programming flash control
// Assumes: 32-bit AHB-Lite register access, 16-bit pointer, 64-word pages
// Notes:   register byte address is four times its index
package spf_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [7:0]  CTRL_INDEX = 8'h37;
  localparam logic [7:0]  LOCK_INDEX = 8'h38;
  localparam logic [9:0]  CTRL_ADDR  = {CTRL_INDEX, 2'b00};
  localparam logic [9:0]  LOCK_ADDR  = {LOCK_INDEX, 2'b00};
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [7:0]  LOCK_RESET = 8'hFF;
  localparam logic [7:0]  LOCK_KEEP  = 8'hC0;

  // accepted patterns of the low five control bits
  localparam logic [4:0]  PAT_FILL   = 5'h01;
  localparam logic [4:0]  PAT_ERASE  = 5'h03;
  localparam logic [4:0]  PAT_WRITE  = 5'h05;
  localparam logic [4:0]  PAT_LOCK   = 5'h09;
  localparam logic [4:0]  PAT_REEN   = 5'h11;

  // ---------------------------------------------------------------------
  // timing: arming window in core clocks
  // ---------------------------------------------------------------------
  localparam logic [2:0]  ARM_CYCLES = 3'h4;
  localparam logic [2:0]  LOAD_MIN   = 3'h2;

  // ---------------------------------------------------------------------
  // pointer layout and section limits
  // ---------------------------------------------------------------------
  localparam int          PAGE_LSB   = 7;
  localparam int          PAGE_MSB   = 14;
  localparam int          WORD_LSB   = 1;
  localparam int          WORD_MSB   = 6;
  localparam int          BUF_WORDS  = 64;
  localparam logic [7:0]  STALLING_SECTION_PAGE  = 8'hE0;
  localparam logic [7:0]  BOOT_PAGE  = 8'hE0;
  localparam logic [15:0] BUF_ERASED = 16'hFFFF;

  // lock byte fields
  localparam int          MLOCK_LO   = 0;
  localparam int          MLOCK_HI   = 1;
  localparam int          ALOCK_LO   = 2;
  localparam int          ALOCK_HI   = 3;
  localparam int          BLOCK_LO   = 4;
  localparam int          BLOCK_HI   = 5;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic store_ready_irq_enable;
    logic concurrent_section_busy;
    logic signature_row_read;
    logic concurrent_section_reenable;
    logic lock_bits_write;
    logic page_write_cmd;
    logic page_erase_cmd;
    logic store_command_enable;
  } spf_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_FLASH
  } spf_state_t;

endpackage : spf_pkg
